// *** hw/scc_pkg.sv ***
// Shared constants for the serial addressed credit cell memory and its reader.
// Assumes both ends are compiled against this package and import it whole.
package scc_pkg;

  // Array shape
  localparam int ADDR_W = 8;
  localparam int COL_W = 3;
  localparam int ROW_W = 5;
  localparam int ARRAY_ROWS = 17;
  localparam int ROW_BITS = 8;
  localparam int STORE_CELLS = 128;
  localparam int STORE_IDX_W = 7;
  localparam int CREDIT_CELLS = 105;
  localparam logic [ROW_W-1:0] ID_ROW = 5'h10;
  localparam logic [ROW_W-1:0] KEY_ROW = 5'h0F;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Mask-fixed user code; value is arbitrary
  localparam logic [ROW_BITS-1:0] USER_ID_CODE = 8'hA5;

  // Erased state of a writable cell reads as credit
  localparam logic [STORE_CELLS-1:0] ERASED_ARRAY = {STORE_CELLS{1'b1}};

  // Link timing, in ns except the pulse length in ms, and the core clock period
  localparam int CORE_PERIOD_NS = 4;
  localparam int CLK_HIGH_NS = 5000;
  localparam int CLK_LOW_NS = 5000;
  localparam int ACCESS_NS = 2000;
  localparam int CLK_TO_PROG_NS = 11000;
  localparam int PROG_RECOVER_NS = 13000;
  localparam int PROG_MS = 50;

  // Derived cycle counts at the core clock rate
  localparam int CLK_HIGH_CYC = CLK_HIGH_NS / CORE_PERIOD_NS;
  localparam int CLK_LOW_CYC = CLK_LOW_NS / CORE_PERIOD_NS;
  localparam int GAP_CYC = (CLK_TO_PROG_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int RECOVER_CYC = (PROG_RECOVER_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int PROG_CYC_DFLT = (PROG_MS * 1000000 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int TIMER_W = 24;

  // Reader sequencer states
  typedef enum logic [2:0] {
    SCC_IDLE,
    SCC_LOW,
    SCC_HIGH,
    SCC_GAP,
    SCC_PROG,
    SCC_RECOV
  } scc_state_e;

endpackage

// *** hw/scc_link_if.sv ***
// Card contact pins between the credit cell memory and its reader.
// Assumes the bench or top resolves nothing else; the open-drain output
// is pulled high here when the card does not drive it.
`timescale 1ns/1ps
interface scc_link_if;
  logic shift_clock_in;
  logic addr_bit;
  logic program_pulse_in;
  logic cell_out_o;
  logic cell_out_oe;
  wire cell_out_level;

  // Open drain with pull-up
  assign cell_out_level = cell_out_oe ? cell_out_o : 1'b1;

  modport card
  (
    input shift_clock_in,
    input addr_bit,
    input program_pulse_in,
    output cell_out_o,
    output cell_out_oe
  );

  modport reader
  (
    output shift_clock_in,
    output addr_bit,
    output program_pulse_in,
    input cell_out_level
  );
endinterface

// *** hw/scc_card.sv ***
// Credit cell memory end: serial address register on the reader's clock,
// one-time-programmable bit array and open-drain cell output on the core clock.
// Assumes the reader keeps to link timing and stops the shift clock between addresses.
//
// How it works
// - Eight-bit address loaded serially, bit per pulse.
// - Reader sends address MSB first, eight pulses.
// - Row and column decode select one cell.
// - Written cell or zero user code bit pulls output low; else released.
// - New cell data valid within 2 us.
// - Debit: 50 ms pulse, over 10 us later.
// - Shift clock max 100 kHz, high 3-6 us.
// - Array 17 by 8, 105 credit cells.
// - Row 16 returns fixed user code.
// - Credit cells start erased; only reset undoes a write.
// - Key row unwritable once fuse is blown.
`timescale 1ns/1ps
module scc_card
  import scc_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYC_DFLT
)
(
  // Core clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Card contacts
  scc_link_if.card lnk,
  // Manufacture fuse, high while intact
  input wire logic i_key_fuse_pin,
  // Status
  output logic o_addr_valid,
  output logic [ADDR_W-1:0] o_sel_addr
);

  // Link domain state
  logic [ADDR_W-1:0] cell_address_bits_reg, cell_address_bits_next;
  logic [2:0] bcnt_reg, bcnt_next;
  logic [ADDR_W-1:0] hold_reg, hold_next;
  logic tog_reg, tog_next;

  // Shift register next values; completed word is held until the next eighth pulse
  always_comb
  begin
    cell_address_bits_next = {cell_address_bits_reg[ADDR_W-2:0], lnk.addr_bit};
    bcnt_next = bcnt_reg + 3'h1;
    hold_next = hold_reg;
    tog_next = tog_reg;
    // Only reset clears the count; a stray pulse misframes later addresses
    if (bcnt_reg == LAST_BIT)
    begin
      hold_next = cell_address_bits_next;
      tog_next = ~tog_reg;
    end
  end

  // Rising edge of the reader's clock takes the bit
  always_ff @(posedge lnk.shift_clock_in or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cell_address_bits_reg <= 8'h00;
      bcnt_reg <= 3'h0;
      hold_reg <= 8'h00;
      tog_reg <= 1'b0;
    end
    else
    begin
      cell_address_bits_reg <= cell_address_bits_next;
      bcnt_reg <= bcnt_next;
      hold_reg <= hold_next;
      tog_reg <= tog_next;
    end
  end

  // Core domain state
  logic tog_s1_reg, tog_s2_reg, tog_s3_reg;
  logic prog_s1_reg, prog_s2_reg;
  logic fuse_s1_reg, fuse_s2_reg;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic valid_reg, valid_next;
  logic [TIMER_W-1:0] pcnt_reg, pcnt_next;
  logic [STORE_CELLS-1:0] array_reg, array_next;
  logic oe_reg, oe_next;
  logic sel_bit;
  logic writable;
  logic [ROW_W-1:0] sel_row;
  logic [COL_W-1:0] sel_col;
  logic [STORE_IDX_W-1:0] sel_idx;

  // Synchronisers: toggle event, programming level, fuse level
  // Pulse and fuse are slow levels, so two stages are enough here
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
      prog_s1_reg <= 1'b0;
      prog_s2_reg <= 1'b0;
      fuse_s1_reg <= 1'b0;
      fuse_s2_reg <= 1'b0;
    end
    else
    begin
      tog_s1_reg <= tog_reg;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
      prog_s1_reg <= lnk.program_pulse_in;
      prog_s2_reg <= prog_s1_reg;
      fuse_s1_reg <= i_key_fuse_pin;
      fuse_s2_reg <= fuse_s1_reg;
    end
  end

  // Decode of the captured address into row and column
  always_comb
  begin
    sel_row = addr_reg[ADDR_W-1:COL_W];
    sel_col = addr_reg[COL_W-1:0];
    sel_idx = addr_reg[STORE_IDX_W-1:0];
    sel_bit = 1'b1;
    writable = 1'b0;
    // Rows past the user code and non-key cells past the credit range read as credit
    if (sel_row == ID_ROW)
    begin
      sel_bit = USER_ID_CODE[sel_col];
    end
    else if (sel_row < ID_ROW)
    begin
      if (32'(sel_idx) < CREDIT_CELLS)
      begin
        sel_bit = array_reg[sel_idx];
        writable = valid_reg;
      end
      // Key row write gate follows the fuse, so a blown fuse freezes it
      else if (sel_row == KEY_ROW)
      begin
        sel_bit = array_reg[sel_idx];
        writable = valid_reg && fuse_s2_reg;
      end
    end
  end

  // Capture, programming timer and array update
  always_comb
  begin
    addr_next = addr_reg;
    valid_next = valid_reg;
    pcnt_next = pcnt_reg;
    array_next = array_reg;
    // Hold word is stable here: the link clock has stopped after pulse eight
    if (tog_s2_reg != tog_s3_reg)
    begin
      addr_next = hold_reg;
      valid_next = 1'b1;
    end
    // Short pulses program nothing; one write per pulse however long
    if (!prog_s2_reg)
    begin
      pcnt_next = '0;
    end
    else if (pcnt_reg != PROG_CYC[TIMER_W-1:0])
    begin
      pcnt_next = pcnt_reg + 24'h000001;
      if (pcnt_next == PROG_CYC[TIMER_W-1:0] && writable)
      begin
        array_next[sel_idx] = 1'b0;
      end
    end
    // Pin follows the cell one cycle after capture or after a write
    oe_next = valid_reg && !sel_bit;
  end

  // Core registers; array resets to fully erased credit
  // Limitation: reset wipes every debit, nothing survives it here
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      addr_reg <= 8'h00;
      valid_reg <= 1'b0;
      pcnt_reg <= '0;
      array_reg <= ERASED_ARRAY;
      oe_reg <= 1'b0;
    end
    else
    begin
      addr_reg <= addr_next;
      valid_reg <= valid_next;
      pcnt_reg <= pcnt_next;
      array_reg <= array_next;
      oe_reg <= oe_next;
    end
  end

  // Outputs from flops; pin only ever pulls low
  assign lnk.cell_out_oe = oe_reg;
  assign lnk.cell_out_o = 1'b0;
  assign o_addr_valid = valid_reg;
  assign o_sel_addr = addr_reg;

endmodule

// *** hw/scc_reader.sv ***
// Reader end: makes the shift clock from the core clock, shifts the
// address out MSB first, optionally applies a programming pulse, then
// samples the open-drain cell output. Assumes one request at a time.
`timescale 1ns/1ps
module scc_reader
  import scc_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYC_DFLT
)
(
  // Core clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Card contacts
  scc_link_if.reader lnk,
  // Request
  input wire logic i_req_valid,
  input wire logic [ADDR_W-1:0] i_req_addr,
  input wire logic i_req_write,
  output logic o_req_ready,
  // Answer: bit high means credit, low means debited
  output logic o_rsp_valid,
  output logic o_rsp_bit
);

  scc_state_e state_reg, state_next;
  logic [TIMER_W-1:0] tmr_reg, tmr_next;
  logic [2:0] bit_reg, bit_next;
  logic [ADDR_W-1:0] sh_reg, sh_next;
  logic wr_reg, wr_next;
  logic clk_reg, clk_next;
  logic dat_reg, dat_next;
  logic prog_reg, prog_next;
  logic rdy_reg, rdy_next;
  logic rv_reg, rv_next;
  logic rb_reg, rb_next;
  logic out_s1_reg, out_s2_reg;
  logic tmr_done;
  logic [TIMER_W-1:0] tmr_end;

  // Card output comes from another domain
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      out_s1_reg <= 1'b1;
      out_s2_reg <= 1'b1;
    end
    else
    begin
      out_s1_reg <= lnk.cell_out_level;
      out_s2_reg <= out_s1_reg;
    end
  end

  // Phase length for the current state
  always_comb
  begin
    tmr_end = '0;
    unique case (state_reg)
      SCC_LOW: tmr_end = TIMER_W'(CLK_LOW_CYC - 1);
      SCC_HIGH: tmr_end = TIMER_W'(CLK_HIGH_CYC - 1);
      SCC_GAP: tmr_end = TIMER_W'(GAP_CYC - 1);
      SCC_PROG: tmr_end = TIMER_W'(PROG_CYC - 1);
      SCC_RECOV: tmr_end = TIMER_W'(RECOVER_CYC - 1);
      SCC_IDLE: tmr_end = '0;
    endcase
    tmr_done = (tmr_reg == tmr_end);
  end

  // Sequencer
  always_comb
  begin
    state_next = state_reg;
    tmr_next = tmr_done ? '0 : tmr_reg + 24'h000001;
    bit_next = bit_reg;
    sh_next = sh_reg;
    wr_next = wr_reg;
    clk_next = clk_reg;
    dat_next = dat_reg;
    prog_next = prog_reg;
    rdy_next = rdy_reg;
    rv_next = 1'b0;
    rb_next = rb_reg;
    unique case (state_reg)
      SCC_IDLE:
      begin
        tmr_next = '0;
        if (i_req_valid && rdy_reg)
        begin
          rdy_next = 1'b0;
          sh_next = i_req_addr;
          wr_next = i_req_write;
          dat_next = i_req_addr[ADDR_W-1];
          bit_next = 3'h0;
          state_next = SCC_LOW;
        end
      end
      SCC_LOW:
      begin
        if (tmr_done)
        begin
          clk_next = 1'b1;
          state_next = SCC_HIGH;
        end
      end
      SCC_HIGH:
      begin
        if (tmr_done)
        begin
          clk_next = 1'b0;
          if (bit_reg == LAST_BIT)
          begin
            state_next = SCC_GAP;
          end
          else
          begin
            bit_next = bit_reg + 3'h1;
            sh_next = {sh_reg[ADDR_W-2:0], 1'b0};
            dat_next = sh_reg[ADDR_W-2];
            state_next = SCC_LOW;
          end
        end
      end
      SCC_GAP:
      begin
        if (tmr_done)
        begin
          if (wr_reg)
          begin
            prog_next = 1'b1;
            state_next = SCC_PROG;
          end
          else
          begin
            rv_next = 1'b1;
            rb_next = out_s2_reg;
            rdy_next = 1'b1;
            state_next = SCC_IDLE;
          end
        end
      end
      SCC_PROG:
      begin
        if (tmr_done)
        begin
          prog_next = 1'b0;
          state_next = SCC_RECOV;
        end
      end
      SCC_RECOV:
      begin
        if (tmr_done)
        begin
          rv_next = 1'b1;
          rb_next = out_s2_reg;
          rdy_next = 1'b1;
          state_next = SCC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg <= SCC_IDLE;
      tmr_reg <= '0;
      bit_reg <= 3'h0;
      sh_reg <= 8'h00;
      wr_reg <= 1'b0;
      clk_reg <= 1'b0;
      dat_reg <= 1'b0;
      prog_reg <= 1'b0;
      rdy_reg <= 1'b1;
      rv_reg <= 1'b0;
      rb_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      wr_reg <= wr_next;
      clk_reg <= clk_next;
      dat_reg <= dat_next;
      prog_reg <= prog_next;
      rdy_reg <= rdy_next;
      rv_reg <= rv_next;
      rb_reg <= rb_next;
    end
  end

  // Outputs straight from flops
  assign lnk.shift_clock_in = clk_reg;
  assign lnk.addr_bit = dat_reg;
  assign lnk.program_pulse_in = prog_reg;
  assign o_req_ready = rdy_reg;
  assign o_rsp_valid = rv_reg;
  assign o_rsp_bit = rb_reg;

endmodule

// *** verif/scc_link_sva.sv ***
// Checker for the card link, watching the interface signals on the core clock.
// Assumes the reader derives the link clock from the core clock at 250 MHz.
`timescale 1ns/1ps
module scc_link_sva
#(
  parameter int PROG_CYC = 200
)
(
  // Core clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Link signals
  input wire logic shift_clock_in,
  input wire logic addr_bit,
  input wire logic program_pulse_in,
  input wire logic cell_out_o,
  input wire logic cell_out_oe,
  input wire logic cell_out_level
);
  int hi_reg, per_reg, age_reg, eighth_reg, pw_reg, pidle_reg;
  logic [2:0] bit_reg;
  logic clk_q_reg;
  logic addr_q_reg;
  wire rise = shift_clock_in & ~clk_q_reg;

  function automatic int sat(input int v);
    return (v < 1000000) ? v + 1 : v;
  endfunction

  // Cycle counters; all but the high-time count saturate so long idle spans never wrap
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      clk_q_reg <= 1'b0;
      addr_q_reg <= 1'b0;
      hi_reg <= 0;
      per_reg <= 1000000;
      age_reg <= 0;
      eighth_reg <= 1000000;
      pw_reg <= 0;
      pidle_reg <= 1000000;
      bit_reg <= 3'h0;
    end
    else
    begin
      clk_q_reg <= shift_clock_in;
      addr_q_reg <= addr_bit;
      hi_reg <= shift_clock_in ? hi_reg + 1 : 0;
      per_reg <= rise ? 0 : sat(per_reg);
      age_reg <= (addr_bit != addr_q_reg) ? 0 : sat(age_reg);
      bit_reg <= rise ? bit_reg + 3'h1 : bit_reg;
      eighth_reg <= (rise && bit_reg == 3'h7) ? 0 : sat(eighth_reg);
      pw_reg <= program_pulse_in ? sat(pw_reg) : 0;
      pidle_reg <= program_pulse_in ? 0 : sat(pidle_reg);
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  // Steps of an address and of a debit
  sequence eighth_rise_s;
    $rose(shift_clock_in) && bit_reg == 3'h7;
  endsequence
  sequence prog_start_s;
    $rose(program_pulse_in);
  endsequence

  clk_high_a: assert property ($fell(shift_clock_in) |-> hi_reg >= 750 && hi_reg <= 1500)
    else $error("shift clock high time out of range");
  clk_rate_a: assert property ($rose(shift_clock_in) |-> per_reg >= 2499)
    else $error("shift clock faster than allowed");
  addr_setup_a: assert property ($rose(shift_clock_in) |-> age_reg >= 125)
    else $error("address bit changed too close to clock rise");
  addr_hold_a: assert property ($changed(addr_bit) |-> per_reg >= 125)
    else $error("address bit changed too soon after clock rise");
  prog_gap_a: assert property (prog_start_s |-> per_reg >= 2500 && bit_reg == 3'h0)
    else $error("programming pulse too early or mid address");
  prog_after_a: assert property (eighth_rise_s |=> !program_pulse_in [*8])
    else $error("programming pulse right after last clock");
  prog_width_a: assert property ($fell(program_pulse_in) |-> pw_reg >= PROG_CYC)
    else $error("programming pulse too short");
  prog_quiet_a: assert property (program_pulse_in |-> !shift_clock_in)
    else $error("shift clock during programming");
  out_settle_a: assert property ($changed(cell_out_oe) |-> eighth_reg <= 500 || pidle_reg <= 16)
    else $error("cell output changed outside access window");
  open_drain_a: assert property (cell_out_oe |-> !cell_out_o && !cell_out_level)
    else $error("enabled output not pulling low");
  addr_done_c: cover property (eighth_rise_s);
endmodule

// *** verif/tb_serial_addressed_credit_cell_memory.sv ***
// Self-checking bench: reader and card joined by the link interface.
// Assumes a shortened programming pulse on both ends and a 250 MHz core clock.
`timescale 1ns/1ps
module tb_serial_addressed_credit_cell_memory;
  import scc_pkg::*;
  localparam int PCYC = 200;
  typedef struct packed {logic [7:0] addr; logic wr; logic fuse; logic exp;} scc_row_s;
  // Address, debit, fuse pin, expected answer bit; key row debited with the fuse blown before a credit debit
  localparam scc_row_s ROWS [4] = '{
    '{8'h81, 1'b0, 1'b1, USER_ID_CODE[1]},
    '{8'h78, 1'b1, 1'b0, 1'b1},
    '{8'h2C, 1'b1, 1'b1, 1'b0},
    '{8'h8C, 1'b1, 1'b1, 1'b1}
  };
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic fuse = 1'b1;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] wire_sh = 8'h00;
  logic [7:0] sel_addr;
  logic req_ready, rsp_valid, rsp_bit, addr_valid;
  int n_errors = 0;
  int check_count = 0;
  int wire_cnt = 0;

  scc_link_if lnk();
  scc_card #(.PROG_CYC(PCYC)) i_scc_card (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .lnk(lnk), .i_key_fuse_pin(fuse), .o_addr_valid(addr_valid), .o_sel_addr(sel_addr));
  scc_reader #(.PROG_CYC(PCYC)) i_scc_reader (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .lnk(lnk), .i_req_valid(req_valid), .i_req_addr(req_addr), .i_req_write(req_write),
    .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp_bit(rsp_bit));
  scc_link_sva #(.PROG_CYC(PCYC)) i_scc_link_sva (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .shift_clock_in(lnk.shift_clock_in), .addr_bit(lnk.addr_bit),
    .program_pulse_in(lnk.program_pulse_in), .cell_out_o(lnk.cell_out_o),
    .cell_out_oe(lnk.cell_out_oe), .cell_out_level(lnk.cell_out_level));

  // Core clock, 4 ns
  always #2 i_core_clk = ~i_core_clk;

  // Bits as they cross the wire, taken on the card's edge
  always @(posedge lnk.shift_clock_in)
  begin
    wire_sh <= {wire_sh[6:0], lnk.addr_bit};
    wire_cnt <= wire_cnt + 1;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One request; a second one offered while busy must be ignored
  task automatic run_req(input logic [7:0] a, input logic w);
    int k;
    wire_cnt = 0;
    @(posedge i_core_clk);
    req_valid <= 1'b1;
    req_addr <= a;
    req_write <= w;
    @(posedge i_core_clk);
    req_valid <= 1'b0;
    @(posedge i_core_clk);
    req_valid <= 1'b1;
    req_addr <= ~a;
    @(posedge i_core_clk);
    req_valid <= 1'b0;
    @(negedge i_core_clk);
    chk("ready while busy", 8'h00, {7'h00, req_ready});
    for (k = 0; k < 40000; k++)
    begin
      @(negedge i_core_clk);
      if (rsp_valid === 1'b1)
        break;
    end
    chk("answer", 8'h01, {7'h00, rsp_valid});
    chk("ready after answer", 8'h01, {7'h00, req_ready});
    chk("bit count", 8'h08, wire_cnt[7:0]);
    chk("wire address", a, wire_sh);
    chk("captured address", a, sel_addr);
    chk("address valid", 8'h01, {7'h00, addr_valid});
  endtask

  // Reset values, table of cases, then a reset in mid transfer
  initial
  begin
    repeat (12) @(negedge i_core_clk);
    chk("pin at reset", 8'h01, {7'h00, lnk.cell_out_level});
    chk("ready at reset", 8'h01, {7'h00, req_ready});
    chk("address valid", 8'h00, {7'h00, addr_valid});
    @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge i_core_clk);
      fuse <= ROWS[i].fuse;
      run_req(ROWS[i].addr, ROWS[i].wr);
      chk("cell bit", {7'h00, ROWS[i].exp}, {7'h00, rsp_bit});
      chk("pin level", {7'h00, ROWS[i].exp}, {7'h00, lnk.cell_out_level});
    end
    @(posedge i_core_clk);
    req_valid <= 1'b1;
    req_addr <= 8'h05;
    req_write <= 1'b1;
    @(posedge i_core_clk);
    req_valid <= 1'b0;
    repeat (3000) @(posedge i_core_clk);
    i_rst_n <= 1'b0;
    repeat (3) @(negedge i_core_clk);
    chk("link clock", 8'h00, {7'h00, lnk.shift_clock_in});
    chk("pin in reset", 8'h01, {7'h00, lnk.cell_out_level});
    chk("address valid", 8'h00, {7'h00, addr_valid});
    @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(negedge i_core_clk);
    chk("pin after reset", 8'h01, {7'h00, lnk.cell_out_level});
    chk("ready after reset", 8'h01, {7'h00, req_ready});
    test_done();
  end

  // Watchdog: one read, three debits and the resets need about 420 us
  initial
  begin
    #450000;
    n_errors++;
    test_done();
  end
endmodule
